// ===== logic/adc_scan_pkg.sv
// Purpose: Shared constants and types of the autoscan converter control block
// Assumes: 8-bit special function register addresses, one machine cycle per ref_clk
// Notes:   Result register addresses are a local choice

package adc_scan_pkg;

   // ************************************************************
   // Register addresses
   // ************************************************************
   localparam logic [7:0] ADDR_CTRL    = 8'hD7;
   localparam logic [7:0] ADDR_SEL     = 8'hE7;
   localparam logic [7:0] ADDR_PINS    = 8'hC7;
   localparam logic [7:0] ADDR_RES_LO0 = 8'hD8;  // D8..DF, one per channel
   localparam logic [7:0] ADDR_RES_HI  = 8'hE8;

   // ************************************************************
   // Control register fields and reset values
   // ************************************************************
   localparam int CTRL_PRE_HI = 7;
   localparam int CTRL_PRE_LO = 6;
   localparam int CTRL_DONE   = 4;
   localparam int CTRL_START  = 3;
   localparam int CTRL_CONT   = 2;
   localparam int CTRL_RISE   = 1;
   localparam int CTRL_FALL   = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] SEL_RESET  = 8'h00;
   localparam logic [7:0] READ_NONE  = 8'h00;

   // ************************************************************
   // Sequencing counts in converter clock ticks (half divisor), channel count and result width
   // ************************************************************
   localparam logic [3:0] SAMPLE_TICKS = 4'h2;
   localparam logic [3:0] CONV_TICKS   = 4'hA;
   localparam int         NUM_CH       = 8;
   localparam int         RES_W        = 10;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'b000001,
      ST_WAIT   = 6'b000010,
      ST_SAMPLE = 6'b000100,
      ST_CONV   = 6'b001000,
      ST_STORE  = 6'b010000,
      ST_SELECT = 6'b100000
   } scan_state_t;

   // Tick spacing in machine cycles: m/2 for m = 2, 4, 6, 8
   function automatic logic [2:0] half_div(input logic [1:0] code);
      half_div = {1'b0, code} + 3'h1;
   endfunction

endpackage

// ===== logic/pin_sync_edge.sv
// Purpose: Two-stage synchroniser with level and edge outputs
// Assumes: Pins are asynchronous to ref_clk
// Notes:   Data stages carry no reset so pins are always shown live

`timescale 1ns/1ps
`default_nettype none

module pin_sync_edge #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] level;
      logic [WIDTH-1:0] rise;
      logic [WIDTH-1:0] fall;
   } sync_state_t;

   sync_state_t s_q;
   sync_state_t s_d;

   // Meta stage feeds only the sync stage; edges look at later stages
   always_comb begin
      s_d       = s_q;
      s_d.meta  = pin_in;
      s_d.sync  = s_q.meta;
      s_d.level = s_q.sync;
      s_d.rise  = s_q.sync & ~s_q.level;
      s_d.fall  = ~s_q.sync & s_q.level;
      if (!resetn) begin
         s_d.rise = '0;
         s_d.fall = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      s_q <= s_d;
   end

   assign level = s_q.level;
   assign rise  = s_q.rise;
   assign fall  = s_q.fall;

endmodule

`default_nettype wire

// ===== logic/adc_prescaler.sv
// Purpose: Converter clock divider producing one tick per bit time
// Assumes: half_div is 1..4 machine cycles
// Notes:   Free running while enabled, so a start sees a phase offset

`timescale 1ns/1ps
`default_nettype none

module adc_prescaler (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       run,
   input  wire logic       restart,
   input  wire logic [2:0] half_div,
   output logic            tick
);

   typedef struct packed {
      logic [2:0] cnt;
      logic       tick;
   } pre_state_t;

   pre_state_t s_q;
   pre_state_t s_d;

   // Tick is high during the last cycle of each divided period
   always_comb begin
      s_d = s_q;
      if (!resetn || !run || restart) begin
         s_d.cnt = 3'h0;
      end else if (s_q.cnt >= half_div - 3'h1) begin
         s_d.cnt = 3'h0;
      end else begin
         s_d.cnt = s_q.cnt + 3'h1;
      end
      // Halted clock gives no ticks in low power
      s_d.tick = resetn && run && (s_d.cnt == half_div - 3'h1);
   end

   always_ff @(posedge ref_clk) begin
      s_q <= s_d;
   end

   assign tick = s_q.tick;

endmodule

`default_nettype wire

// ===== logic/adc_autoscan_control.sv
// Purpose: Autoscan sequencing, result buffers and registers of the 8-channel converter
// Assumes: SFR port on ref_clk, read data one cycle after sfr_rd, low_power from CPU logic
// Notes:   Converter core samples while conv_sample is high, result taken in store cycle

`timescale 1ns/1ps
`default_nettype none

module adc_autoscan_control (
   input  wire logic                          ref_clk,
   input  wire logic                          resetn,
   input  wire logic [7:0]                    sfr_addr,
   input  wire logic [7:0]                    sfr_wdata,
   input  wire logic                          sfr_wr,
   input  wire logic                          sfr_rd,
   output logic      [7:0]                    sfr_rdata,
   input  wire logic                          low_power,
   input  wire logic                          ext_start_pin,
   input  wire logic [7:0]                    analog_input_pins,
   input  wire logic [adc_scan_pkg::RES_W-1:0] conv_result,
   output logic      [2:0]                    conv_channel,
   output logic                               conv_sample,
   output logic                               conv_busy,
   output logic                               scan_done_flag
);
   import adc_scan_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      scan_state_t                  st;
      logic [1:0]                   pre;
      logic                         cont;
      logic                         rise_en;
      logic                         fall_en;
      logic                         start;
      logic                         done;
      logic                         pending;
      logic [7:0]                   sel;
      logic [7:0]                   loop_sel;
      logic [2:0]                   chan;
      logic [3:0]                   tick_cnt;
      logic [3:0]                   sel_cnt;
      logic [NUM_CH-1:0][RES_W-1:0] res;
      logic [1:0]                   hi;
      logic [7:0]                   rdata;
      logic                         sample;
      logic                         busy;
   } ctrl_state_t;

   ctrl_state_t s_q;
   ctrl_state_t s_d;

   logic       tick;
   logic       restart;
   logic [2:0] half;
   logic [7:0] pins_level;
   logic       ext_rise;
   logic       ext_fall;

   // Lowest set bit at or above a position; bit 3 of the answer flags none
   function automatic logic [3:0] next_set(input logic [7:0] mask, input logic [3:0] from);
      logic [3:0] r;
      r = 4'h8;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (mask[i] && (4'(i) >= from)) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // ************************************************************
   // Synchronisers and divider
   // ************************************************************
   pin_sync_edge #(
      .WIDTH (1)
   ) u_ext_sync (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .pin_in  (ext_start_pin),
      .level   (),
      .rise    (ext_rise),
      .fall    (ext_fall)
   );

   pin_sync_edge #(
      .WIDTH (8)
   ) u_pin_sync (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .pin_in  (analog_input_pins),
      .level   (pins_level),
      .rise    (),
      .fall    ()
   );

   assign half = half_div(s_q.pre);
   // Realign the divided clock as each sample begins; a stale tick after a divisor change
   // would otherwise cut the first sampling period short
   assign restart = ((s_q.st == ST_SELECT) && (s_q.sel_cnt == {half, 1'b0} - 4'h1))
                  || ((s_q.st == ST_WAIT) && tick);

   adc_prescaler u_pre (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .run      (~low_power),
      .restart  (restart),
      .half_div (half),
      .tick     (tick)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic       wr_ctrl;
      logic       wr_sel;
      logic       req;
      logic       done_eff;
      logic [3:0] first;
      logic [3:0] nxt;
      wr_ctrl  = sfr_wr && (sfr_addr == ADDR_CTRL);
      wr_sel   = sfr_wr && (sfr_addr == ADDR_SEL);
      req      = 1'b0;
      done_eff = s_q.done;
      first    = next_set(s_q.sel, 4'h0);
      nxt      = 4'h8;
      s_d      = s_q;

      // Control and selection writes
      if (wr_ctrl) begin
         s_d.pre     = sfr_wdata[CTRL_PRE_HI:CTRL_PRE_LO];
         s_d.cont    = sfr_wdata[CTRL_CONT];
         s_d.rise_en = sfr_wdata[CTRL_RISE];
         s_d.fall_en = sfr_wdata[CTRL_FALL];
         // Writing one leaves the flag alone
         done_eff    = s_q.done & sfr_wdata[CTRL_DONE];
         s_d.done    = done_eff;
         req         = sfr_wdata[CTRL_START];
         if (!sfr_wdata[CTRL_START]) begin
            s_d.pending = 1'b0;
            if (s_q.start) begin
               s_d.start  = 1'b0;
               s_d.st     = ST_IDLE;
               s_d.sample = 1'b0;
               s_d.busy   = 1'b0;
            end
         end
      end
      if (wr_sel) begin
         s_d.sel = sfr_wdata;
      end
      if ((ext_rise && s_q.rise_en) || (ext_fall && s_q.fall_en)) begin
         req = 1'b1;
      end

      // Start requests: ignored while running, deferred while done
      if (!s_q.start && !low_power) begin
         if (done_eff) begin
            s_d.pending = s_q.pending | req;
         end else if (req || s_q.pending) begin
            s_d.pending = 1'b0;
            if (first[3] == 1'b0) begin
               s_d.start    = 1'b1;
               s_d.loop_sel = s_q.sel;
               s_d.chan     = first[2:0];
               s_d.st       = ST_WAIT;
            end
         end
      end

      // Sample and conversion run in counted divided-clock ticks; store and select run in machine cycles
      unique case (s_q.st)
         ST_IDLE: begin
            s_d.sample = 1'b0;
            s_d.busy   = 1'b0;
         end
         ST_WAIT: begin
            // Phase of the free divider sets the start delay
            if (tick) begin
               s_d.st       = ST_SAMPLE;
               s_d.tick_cnt = 4'h0;
               s_d.sample   = 1'b1;
               s_d.busy     = 1'b1;
            end
         end
         ST_SAMPLE: begin
            if (tick) begin
               if (s_q.tick_cnt == SAMPLE_TICKS - 4'h1) begin
                  s_d.st       = ST_CONV;
                  s_d.tick_cnt = 4'h0;
                  s_d.sample   = 1'b0;
               end else begin
                  s_d.tick_cnt = s_q.tick_cnt + 4'h1;
               end
            end
         end
         ST_CONV: begin
            if (tick) begin
               if (s_q.tick_cnt == CONV_TICKS - 4'h1) begin
                  s_d.st       = ST_STORE;
                  s_d.tick_cnt = 4'h0;
               end else begin
                  s_d.tick_cnt = s_q.tick_cnt + 4'h1;
               end
            end
         end
         ST_STORE: begin
            // One machine cycle to take the result
            s_d.res[s_q.chan] = conv_result;
            s_d.busy          = 1'b0;
            s_d.sel_cnt       = 4'h1;
            nxt               = next_set(s_q.loop_sel, {1'b0, s_q.chan} + 4'h1);
            if (nxt[3] == 1'b0) begin
               s_d.chan = nxt[2:0];
               s_d.st   = ST_SELECT;
            end else begin
               // Last channel of the loop; set wins over a same-cycle clear
               s_d.done = 1'b1;
               if (s_q.cont && (first[3] == 1'b0)) begin
                  s_d.loop_sel = s_q.sel;
                  s_d.chan     = first[2:0];
                  s_d.st       = ST_SELECT;
               end else begin
                  s_d.start = 1'b0;
                  s_d.st    = ST_IDLE;
               end
            end
         end
         ST_SELECT: begin
            // Channel selection fills the gap up to seven m
            if (restart) begin
               s_d.st       = ST_SAMPLE;
               s_d.tick_cnt = 4'h0;
               s_d.sample   = 1'b1;
               s_d.busy     = 1'b1;
            end else begin
               s_d.sel_cnt = s_q.sel_cnt + 4'h1;
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase

      // A software abort in the same cycle overrides the sequencer
      if (wr_ctrl && !sfr_wdata[CTRL_START] && s_q.start) begin
         s_d.start  = 1'b0;
         s_d.st     = ST_IDLE;
         s_d.sample = 1'b0;
         s_d.busy   = 1'b0;
      end

      // Low power: abort, drop start, results untouched
      if (low_power) begin
         s_d.start   = 1'b0;
         s_d.pending = 1'b0;
         s_d.st      = ST_IDLE;
         s_d.sample  = 1'b0;
         s_d.busy    = 1'b0;
      end

      // Register reads, answered one cycle later
      if (sfr_rd) begin
         if (sfr_addr == ADDR_CTRL) begin
            // Start bit shows the effective state, not a deferred request
            s_d.rdata = {s_q.pre, 1'b0, s_q.done, s_q.start,
                         s_q.cont, s_q.rise_en, s_q.fall_en};
         end else if (sfr_addr == ADDR_SEL) begin
            s_d.rdata = s_q.sel;
         end else if (sfr_addr == ADDR_PINS) begin
            s_d.rdata = pins_level;
         end else if (sfr_addr[7:3] == ADDR_RES_LO0[7:3]) begin
            s_d.rdata = s_q.res[sfr_addr[2:0]][7:0];
            s_d.hi    = s_q.res[sfr_addr[2:0]][9:8];
         end else if (sfr_addr == ADDR_RES_HI) begin
            s_d.rdata = {6'h00, s_q.hi};
         end else begin
            s_d.rdata = READ_NONE;
         end
      end

      // Synchronous reset; result buffers and high latch keep contents
      if (!resetn) begin
         s_d.st       = ST_IDLE;
         {s_d.pre, s_d.cont, s_d.rise_en, s_d.fall_en} = {CTRL_RESET[7:6], CTRL_RESET[2:0]};
         s_d.start    = CTRL_RESET[CTRL_START];
         s_d.done     = CTRL_RESET[CTRL_DONE];
         s_d.sel      = SEL_RESET;
         s_d.pending  = 1'b0;
         s_d.loop_sel = SEL_RESET;
         s_d.chan     = 3'h0;
         s_d.tick_cnt = 4'h0;
         s_d.sel_cnt  = 4'h0;
         s_d.rdata    = READ_NONE;
         s_d.sample   = 1'b0;
         s_d.busy     = 1'b0;
         s_d.res      = s_q.res;
         s_d.hi       = s_q.hi;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge ref_clk) begin
      s_q <= s_d;
   end

   // Outputs straight from state flops
   assign sfr_rdata      = s_q.rdata;
   assign conv_channel   = s_q.chan;
   assign conv_sample    = s_q.sample;
   assign conv_busy      = s_q.busy;
   assign scan_done_flag = s_q.done;

endmodule

`default_nettype wire

// ===== sim/conv_core_model.sv
// Purpose: Behavioural converter core facing the scan sequencer
// Assumes: Result is taken in the store cycle, the last cycle of conv_busy
// Notes:   Outside busy the bus toggles, so late capture fails
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
   input  wire logic       ref_clk,
   input  wire logic [2:0] conv_channel,
   input  wire logic       conv_busy,
   output logic      [9:0] conv_result
);
   logic [9:0] junk_q = 10'h2AA;
   // ********************
   // Channel-coded answer
   // ********************
   // Junk flips each cycle; its 2AA phase equals the channel 2 answer, so a stale capture can match by luck
   always_ff @(posedge ref_clk) begin
      junk_q <= ~junk_q;
   end
   // Valid only while conv_busy, which covers the store cycle
   assign conv_result = conv_busy ?
                        {conv_channel[1:0], 5'h15, conv_channel} : junk_q;
endmodule
`default_nettype wire

// ===== sim/adc_scan_properties.sv
// Purpose: Port-level timing checks of the autoscan converter control
// Assumes: Prescaler code is changed only while no conversion runs
// Notes:   Aborts excuse short runs until the next conversion starts
`timescale 1ns/1ps
`default_nettype none
module adc_scan_properties
   import adc_scan_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       resetn,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic       low_power,
   input wire logic [7:0] analog_input_pins,
   input wire logic       conv_sample,
   input wire logic       conv_busy,
   input wire logic       scan_done_flag
);
   logic [5:0] m_q, s_cnt_q, b_cnt_q;
   logic [7:0] pin_prev_q;
   logic [1:0] pin_age_q;
   logic       cut_q, busy_q, clr_q;
   wire        ctrl_wr = sfr_wr && sfr_addr == ADDR_CTRL;
   // ********************
   // Helper state
   // ********************
   // Divisor, run lengths and pin age; aborts mark runs as cut short
   always_ff @(posedge ref_clk) begin
      busy_q     <= conv_busy;
      pin_prev_q <= analog_input_pins;
      clr_q      <= ctrl_wr && !sfr_wdata[CTRL_DONE];
      s_cnt_q    <= conv_sample ? s_cnt_q + 6'h01 : 6'h00;
      b_cnt_q    <= conv_busy ? b_cnt_q + 6'h01 : 6'h00;
      if (!resetn) begin
         m_q       <= 6'h02;
         cut_q     <= 1'b0;
         pin_age_q <= 2'h0;
      end else begin
         if (ctrl_wr)
            m_q <= {2'h0, sfr_wdata[7:6], 1'b0} + 6'h02;
         if (low_power || (ctrl_wr && !sfr_wdata[CTRL_START]))
            cut_q <= 1'b1;
         else if (conv_busy && !busy_q)
            cut_q <= 1'b0;
         if (analog_input_pins != pin_prev_q)
            pin_age_q <= 2'h0;
         else if (pin_age_q != 2'h3)
            pin_age_q <= pin_age_q + 2'h1;
      end
   end
   // ********************
   // Assertions
   // ********************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_sampling; conv_sample ##1 (conv_sample || !conv_busy); endsequence
   property p_hi_zero; sfr_rd && sfr_addr == ADDR_RES_HI |=> sfr_rdata[7:2] == 6'h00; endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("high byte upper bits set");
   property p_pins;
      sfr_rd && sfr_addr == ADDR_PINS && pin_age_q == 2'h3 |=>
         sfr_rdata == $past(analog_input_pins);
   endproperty
   a_pins: assert property (p_pins) else $error("pin register not live");
   property p_samp_len; $fell(conv_sample) && !cut_q |-> s_cnt_q == m_q; endproperty
   a_samp_len: assert property (p_samp_len) else $error("sample length wrong");
   property p_busy_len; $fell(conv_busy) && !cut_q |-> b_cnt_q == m_q * 6 + 1; endproperty
   a_busy_len: assert property (p_busy_len) else $error("conversion length wrong");
   property p_conv_start; $rose(conv_busy) |-> s_sampling; endproperty
   a_conv_start: assert property (p_conv_start) else $error("no sampling first");
   property p_done_rise; $rose(scan_done_flag) |-> $past(conv_busy) && !conv_busy; endproperty
   a_done_rise: assert property (p_done_rise) else $error("done not after store");
   property p_done_fall; $fell(scan_done_flag) |-> clr_q; endproperty
   a_done_fall: assert property (p_done_fall) else $error("done cleared by hardware");
   property p_power; low_power [*2] |-> !conv_busy && !conv_sample; endproperty
   a_power: assert property (p_power) else $error("conversion runs in low power");
endmodule
bind adc_autoscan_control adc_scan_properties u_props (
   .ref_clk, .resetn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
   .low_power, .analog_input_pins, .conv_sample, .conv_busy, .scan_done_flag
);
`default_nettype wire

// ===== sim/adc_autoscan_control_test.sv
// Purpose: Register-level tests of the autoscan converter control
// Assumes: Core model returns a channel-coded result per conversion
// Notes:   Fixed waits where a scan must be shown not to start, and for reset, aborts and pin sync
`timescale 1ns/1ps
`default_nettype none
module adc_autoscan_control_test;
   import adc_scan_pkg::*;
   logic       ref_clk, resetn, sfr_wr, sfr_rd, low_power, ext_start_pin;
   logic       conv_sample, conv_busy, scan_done_flag, samp_q;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, analog_input_pins;
   logic [9:0] conv_result;
   logic [2:0] conv_channel;
   int         n_fail, tests_run, cyc, n_samp, blen, gap, t_samp, k, n;
   int         chq[$];
   int         chs[4] = '{0, 2, 5, 7};
   int         chc[4] = '{0, 1, 2, 2};
   adc_autoscan_control dut (
      .ref_clk, .resetn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
      .low_power, .ext_start_pin, .analog_input_pins, .conv_result,
      .conv_channel, .conv_sample, .conv_busy, .scan_done_flag);
   conv_core_model core (.ref_clk, .conv_channel, .conv_busy, .conv_result);
   always #2.5 ref_clk = ~ref_clk;
   // ********************
   // Monitor and tasks
   // ********************
   // Stamp each sampling start; the ceiling cuts a hung run short
   always @(posedge ref_clk) begin
      cyc++;
      samp_q <= conv_sample;
      if (conv_busy === 1'b1)
         blen++;
      if (conv_sample === 1'b1 && samp_q === 1'b0) begin
         n_samp++;
         gap = cyc - t_samp;
         t_samp = cyc;
         chq.push_back(conv_channel);
      end
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   function automatic logic [9:0] ev(int c);
      ev = {c[1:0], 5'h15, c[2:0]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_wdata <= v;
      sfr_wr <= 1'b1;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic chk(input string s, input logic [9:0] got, input logic [9:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", s, exp, got);
      end
   endtask
   // Read data is registered, so it is taken one cycle after the strobe
   task automatic rc(input string s, input logic [7:0] a, input logic [9:0] exp);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge ref_clk);
      sfr_rd <= 1'b0;
      #1;
      chk(s, {2'h0, sfr_rdata}, exp);
   endtask
   task automatic wait_done;
      @(posedge ref_clk);
      for (int i = 0; i < 400 && scan_done_flag !== 1'b1; i++)
         @(posedge ref_clk);
      @(posedge ref_clk);
   endtask
   task automatic wait_n(input int c);
      for (int i = 0; i < 3000 && chq.size() < c; i++)
         @(posedge ref_clk);
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ********************
   // Test sequence
   // ********************
   initial begin
      ref_clk = 1'b0;
      resetn = 1'b0;
      {sfr_wr, sfr_rd, low_power, ext_start_pin} = 4'h0;
      {sfr_addr, sfr_wdata} = 16'h0000;
      analog_input_pins = 8'h5A;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rc("ctrl", ADDR_CTRL, 10'h000);
      rc("sel", ADDR_SEL, 10'h000);
      rc("unmapped", 8'h00, 10'h000);
      wr(ADDR_CTRL, 8'h10);
      rc("done_sw", ADDR_CTRL, 10'h000);
      // Empty selection: software and both pin edges refused
      wr(ADDR_CTRL, 8'h0B);
      ext_start_pin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      ext_start_pin <= 1'b0;
      wait_done();
      chk("no_sel", 10'(n_samp), 10'h000);
      rc("no_sel_ctrl", ADDR_CTRL, 10'h003);
      $display("Test reset and refusal done");
      // One-time scan of four channels at divisor 8
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_SEL, 8'hA5);
      wr(ADDR_CTRL, 8'hC8);
      blen = 0;
      k = 0;
      while (conv_sample !== 1'b1 && k < 9) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      chk("start_dly", 10'(k >= 1 && k <= 4), 10'h001);
      wait_done();
      chk("gap", 10'(gap), 10'h038);
      chk("busy_len", 10'(blen), 10'h0C4);
      foreach (chs[i]) begin
         chk("chan", 10'(chq[i]), 10'(chs[i]));
         rc("res_lo", ADDR_RES_LO0 + 8'(chs[i]), ev(chs[i]) & 10'h0FF);
         rc("res_hi", ADDR_RES_HI, ev(chs[i]) >> 8);
      end
      rc("ctrl_end", ADDR_CTRL, 10'h0D0);
      rc("hi_hold", ADDR_RES_HI, ev(7) >> 8);
      // Start while done is set waits for the clear
      n = n_samp;
      wr(ADDR_CTRL, 8'h18);
      repeat (20) @(posedge ref_clk);
      chk("deferred", 10'(n_samp - n), 10'h000);
      rc("defer_ctrl", ADDR_CTRL, 10'h010);
      wr(ADDR_CTRL, 8'h08);
      wait_done();
      chk("released", 10'(n_samp - n), 10'h004);
      // Results survive reset and ignore writes
      wr(ADDR_RES_LO0, 8'h00);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rc("res_keep", ADDR_RES_LO0, ev(0) & 10'h0FF);
      rc("sel_rst", ADDR_SEL, 10'h000);
      $display("Test one-time scan done");
      // Continuous scan, selection change, software abort
      wr(ADDR_SEL, 8'h03);
      chq.delete();
      wr(ADDR_CTRL, 8'h0C);
      wait_n(1);
      wr(ADDR_SEL, 8'h04);
      wait_n(4);
      foreach (chc[i])
         chk("cont_chan", 10'(chq[i]), 10'(chc[i]));
      wr(ADDR_CTRL, 8'h04);
      repeat (3) @(negedge ref_clk);
      chk("abort", {9'h000, conv_busy}, 10'h000);
      n = n_samp;
      wait_done();
      chk("stopped", 10'(n_samp - n), 10'h000);
      $display("Test continuous scan done");
      // Pin edges against each enable pair and prescaler code
      wr(ADDR_SEL, 8'h01);
      for (int e = 0; e < 4; e++) begin
         wr(ADDR_CTRL, {e[1:0], 4'h0, e[1:0]});
         chq.delete();
         blen = 0;
         ext_start_pin <= 1'b1;
         wait_done();
         chk("rise", 10'(chq.size()), 10'(e[1]));
         chk("len", 10'(blen), 10'(e[1] * (12 * (e + 1) + 1)));
         wr(ADDR_CTRL, {e[1:0], 4'h0, e[1:0]});
         ext_start_pin <= 1'b0;
         wait_done();
         chk("fall", 10'(chq.size()), 10'(e[1] + e[0]));
         wr(ADDR_CTRL, 8'h00);
      end
      $display("Test pin start done");
      // Low power mid-loop aborts and halts
      wr(ADDR_SEL, 8'hFF);
      chq.delete();
      wr(ADDR_CTRL, 8'h0C);
      wait_n(2);
      low_power <= 1'b1;
      repeat (3) @(negedge ref_clk);
      chk("lp_busy", {8'h00, conv_busy, conv_sample}, 10'h000);
      @(posedge ref_clk);
      low_power <= 1'b0;
      n = n_samp;
      rc("lp_ctrl", ADDR_CTRL, 10'h004);
      wait_done();
      chk("lp_halt", 10'(n_samp - n), 10'h000);
      analog_input_pins <= 8'h3C;
      repeat (4) @(posedge ref_clk);
      rc("pins", ADDR_PINS, 10'h03C);
      $display("Test low power and pins done");
      report_and_stop();
   end
endmodule
`default_nettype wire
